/* verilog/eoc_pkg.sv */
// Constants, register map and frame layout of the encoder config block.
// Assumes 32-bit APB data and a 40 MHz ref_clk.
package eoc_pkg;
  localparam int ANG_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int EVT_W = 4;
  // Fuse layout
  localparam int OTP_W = 13;
  localparam int OTP_ZERO_LSB = 0;
  localparam int OTP_CCW = 10;
  localparam int OTP_MAGCOMP = 11;
  localparam int OTP_PWMDIS = 12;
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ZERO = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_OTP = 8'h10;
  localparam logic [ADDR_W-1:0] REG_POS = 8'h14;
  // Control fields
  localparam int CTRL_ALIGN = 0;
  localparam int CTRL_MAGCOMP = 1;
  localparam int CTRL_CCW = 2;
  localparam int CTRL_PWMDIS = 3;
  localparam int CTRL_RELOAD = 4;
  // Status and mask fields
  localparam int EV_FRAME = 0;
  localparam int EV_PROG_OK = 1;
  localparam int EV_PROG_REFUSED = 2;
  localparam int EV_ALIGN_GOOD = 3;
  // Position register fields
  localparam int POS_INC = 10;
  localparam int POS_DEC = 11;
  // Frame fields
  localparam int FR_ANG_LSB = 6;
  localparam int FR_INC = 5;
  localparam int FR_DEC = 4;
  localparam int FR_ALIGN = 3;
  localparam int FR_OTP_LSB = FRAME_W - OTP_W;
  // Misalignment threshold for a well centred magnet
  localparam logic [ANG_W-1:0] ALIGN_GOOD_LIMIT = 10'h020;
  typedef enum logic [1:0] {
    EOC_LK_IDLE = 2'b00,
    EOC_LK_SEND = 2'b01,
    EOC_LK_RECV = 2'b11
  } eoc_link_e;
endpackage

/* verilog/eoc_fuse_array.sv */
// One-time-programmable fuse store of the encoder config block.
// Assumes prog_pulse is a one-cycle pulse on ref_clk; blank_n models a
// factory-fresh part and is never asserted in service.
`timescale 1ns/1ps
`default_nettype none
module eoc_fuse_array
  import eoc_pkg::*;
#(
  parameter int W = eoc_pkg::OTP_W
) (
  input wire logic ref_clk,
  input wire logic blank_n,
  input wire logic prog_pulse,
  input wire logic programming_voltage_input_ok,
  input wire logic [W-1:0] prog_data,
  output logic [W-1:0] fuse_q,
  output logic prog_done,
  output logic prog_refused
);
  // Blank fuses read 0, blown fuses read 1
  always_ff @(posedge ref_clk) begin
    if (!blank_n) begin
      fuse_q <= '0;
    end else if (prog_pulse && programming_voltage_input_ok) begin
      fuse_q <= fuse_q | prog_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!blank_n) begin
      prog_done <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      prog_done <= prog_pulse && programming_voltage_input_ok;
      prog_refused <= prog_pulse && !programming_voltage_input_ok;
    end
  end
endmodule // eoc_fuse_array
`default_nettype wire

/* verilog/eoc_encoder_cfg.sv */
// Encoder serial readout, alignment mode and OTP configuration.
// Assumes an APB master on ref_clk; serial pins are asynchronous.
//
// Operation
// - Alignment mode puts misalignment magnitude into the 10-bit angle field
// - Reading below 32 sets both field flags, drives both flag pins low
// - Software command returns the device from alignment to normal mode
// - Zero position and user parameters may change at any time
// - Power-up loads configuration from fuses, discarding run-time changes
// - Unprogrammed fuses read 0, programmed fuses read 1
// - Repeated programming may set 0 bits; a 1 never returns to 0
// - Without programming voltage, a programming cycle leaves fuses unchanged
// - Zero offset is ten bits plus a direction bit, temporary or fused
// - Direction bit inverts both incremental and absolute outputs
`timescale 1ns/1ps
`default_nettype none
module eoc_encoder_cfg
  import eoc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic otp_blank_n,
  input wire logic [eoc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eoc_pkg::DATA_W-1:0] pwdata,
  output logic [eoc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [eoc_pkg::ANG_W-1:0] raw_angle,
  input wire logic [eoc_pkg::ANG_W-1:0] misalign_mag,
  input wire logic field_too_weak,
  input wire logic field_too_strong,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe,
  input wire logic prog_pin,
  input wire logic programming_voltage_input,
  output logic field_increase_flag_n,
  output logic field_decrease_flag_n,
  output logic [eoc_pkg::ANG_W-1:0] abs_position,
  output logic inc_step,
  output logic inc_dir,
  output logic magnet_compensation_enable,
  output logic pulse_width_output_disable,
  output logic irq
);
  import eoc_pkg::*;

  function automatic logic [ANG_W-1:0] wrap_sub(
    input logic [ANG_W-1:0] a,
    input logic [ANG_W-1:0] b
  );
    wrap_sub = a - b;
  endfunction

  // Pin synchronisers
  logic [1:0] cs_sync_ff, sck_sync_ff, din_sync_ff, prog_sync_ff;
  logic [1:0] programming_voltage_input_sync_ff;
  logic cs_d_ff, sck_d_ff;
  logic cs_s, sck_s, din_s, prog_s, programming_voltage_input_s;
  logic cs_fall, cs_rise, sck_rise;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cs_sync_ff <= 2'h3;
      sck_sync_ff <= 2'h0;
      din_sync_ff <= 2'h0;
      prog_sync_ff <= 2'h0;
      programming_voltage_input_sync_ff <= 2'h0;
      cs_d_ff <= 1'b1;
      sck_d_ff <= 1'b0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], chip_select_n};
      sck_sync_ff <= {sck_sync_ff[0], serial_clk};
      din_sync_ff <= {din_sync_ff[0], serial_data_i};
      prog_sync_ff <= {prog_sync_ff[0], prog_pin};
      programming_voltage_input_sync_ff <= {programming_voltage_input_sync_ff[0], programming_voltage_input};
      cs_d_ff <= cs_sync_ff[1];
      sck_d_ff <= sck_sync_ff[1];
    end
  end

  assign cs_s = cs_sync_ff[1];
  assign sck_s = sck_sync_ff[1];
  assign din_s = din_sync_ff[1];
  assign prog_s = prog_sync_ff[1];
  assign programming_voltage_input_s = programming_voltage_input_sync_ff[1];
  assign cs_fall = cs_d_ff && !cs_s;
  assign cs_rise = !cs_d_ff && cs_s;
  assign sck_rise = !sck_d_ff && sck_s;

  // Configuration registers
  logic align_mode_ff, magcomp_ff, ccw_ff, pwmdis_ff, load_pend_ff;
  logic [ANG_W-1:0] zero_ff;
  logic [EVT_W-1:0] status_ff, mask_ff, evt;
  logic [OTP_W-1:0] fuse_q;
  logic apb_wr, apb_setup;
  logic wr_ctrl, wr_zero, reload_req;

  assign apb_wr = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign wr_ctrl = apb_wr && (paddr == REG_CTRL);
  assign wr_zero = apb_wr && (paddr == REG_ZERO);
  assign reload_req = wr_ctrl && pwdata[CTRL_RELOAD];

  // Fuse image reloads after reset release; run-time edits lost
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      load_pend_ff <= 1'b1;
    end else begin
      load_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      zero_ff <= '0;
      ccw_ff <= 1'b0;
      magcomp_ff <= 1'b0;
      pwmdis_ff <= 1'b0;
    end else if (load_pend_ff || reload_req) begin
      zero_ff <= fuse_q[OTP_ZERO_LSB +: ANG_W];
      ccw_ff <= fuse_q[OTP_CCW];
      magcomp_ff <= fuse_q[OTP_MAGCOMP];
      pwmdis_ff <= fuse_q[OTP_PWMDIS];
    end else begin
      if (wr_zero) begin
        zero_ff <= pwdata[ANG_W-1:0];
      end
      if (wr_ctrl) begin
        magcomp_ff <= pwdata[CTRL_MAGCOMP];
        ccw_ff <= pwdata[CTRL_CCW];
        pwmdis_ff <= pwdata[CTRL_PWMDIS];
      end
    end
  end

  // Alignment mode entered and left by software
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      align_mode_ff <= 1'b0;
    end else if (wr_ctrl) begin
      align_mode_ff <= pwdata[CTRL_ALIGN];
    end
  end

  assign magnet_compensation_enable = magcomp_ff;
  assign pulse_width_output_disable = pwmdis_ff;

  // Field flags
  logic inc_flag_ff, dec_flag_ff, align_good;
  assign align_good = misalign_mag < ALIGN_GOOD_LIMIT;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      inc_flag_ff <= 1'b0;
      dec_flag_ff <= 1'b0;
    end else if (align_mode_ff) begin
      inc_flag_ff <= align_good;
      dec_flag_ff <= align_good;
    end else begin
      inc_flag_ff <= field_too_weak;
      dec_flag_ff <= field_too_strong;
    end
  end

  assign field_increase_flag_n = !inc_flag_ff;
  assign field_decrease_flag_n = !dec_flag_ff;

  // Absolute and incremental position
  logic [ANG_W-1:0] pos_ff, nxt_pos, pos_step;
  logic step_ff, dir_ff;

  always_comb begin
    nxt_pos = wrap_sub(raw_angle, zero_ff);
    if (ccw_ff) begin
      nxt_pos = wrap_sub('0, nxt_pos);
    end
  end

  assign pos_step = wrap_sub(nxt_pos, pos_ff);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pos_ff <= '0;
      step_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else begin
      pos_ff <= nxt_pos;
      step_ff <= (pos_step != '0);
      if (pos_step != '0) begin
        dir_ff <= !pos_step[ANG_W-1];
      end
    end
  end

  assign abs_position = pos_ff;
  assign inc_step = step_ff;
  assign inc_dir = dir_ff;

  // Serial link
  eoc_link_e link_ff;
  logic [FRAME_W-1:0] shift_ff, frame;
  logic [CNT_W-1:0] bits_ff;
  logic prog_pulse_ff, frame_done_ff;
  logic prog_done, prog_refused;
  logic [ANG_W-1:0] ang_field;

  assign ang_field = align_mode_ff ? misalign_mag : pos_ff;

  always_comb begin
    frame = '0;
    frame[FR_ANG_LSB +: ANG_W] = ang_field;
    frame[FR_INC] = inc_flag_ff;
    frame[FR_DEC] = dec_flag_ff;
    frame[FR_ALIGN] = align_mode_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      link_ff <= EOC_LK_IDLE;
      shift_ff <= '0;
      bits_ff <= '0;
    end else begin
      case (link_ff)
        EOC_LK_IDLE: begin
          bits_ff <= '0;
          if (cs_fall && prog_s && !sck_s) begin
            link_ff <= EOC_LK_RECV;
            shift_ff <= '0;
          end else if (cs_fall && prog_s) begin
            link_ff <= EOC_LK_SEND;
            shift_ff <= {fuse_q, {FR_OTP_LSB{1'b0}}};
          end else if (cs_fall) begin
            link_ff <= EOC_LK_SEND;
            shift_ff <= frame;
          end
        end
        EOC_LK_SEND: begin
          if (cs_rise) begin
            link_ff <= EOC_LK_IDLE;
          end else if (sck_rise) begin
            shift_ff <= {shift_ff[FRAME_W-2:0], 1'b0};
          end
        end
        EOC_LK_RECV: begin
          if (cs_rise) begin
            link_ff <= EOC_LK_IDLE;
          end else if (sck_rise) begin
            shift_ff <= {shift_ff[FRAME_W-2:0], din_s};
            bits_ff <= bits_ff + CNT_W'(1);
          end
        end
        default: begin
          link_ff <= EOC_LK_IDLE;
        end
      endcase
    end
  end

  // Programming cycle at end of a receive frame of exactly 13 bits
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prog_pulse_ff <= 1'b0;
      frame_done_ff <= 1'b0;
    end else begin
      prog_pulse_ff <= (link_ff == EOC_LK_RECV) && cs_rise &&
                       (bits_ff == CNT_W'(OTP_W));
      frame_done_ff <= (link_ff == EOC_LK_SEND) && cs_rise;
    end
  end

  assign serial_data_o = shift_ff[FRAME_W-1];
  assign serial_data_oe = (link_ff == EOC_LK_SEND) && !cs_s;

  eoc_fuse_array #(
    .W(OTP_W)
  ) u_fuse (
    .ref_clk(ref_clk),
    .blank_n(otp_blank_n),
    .prog_pulse(prog_pulse_ff),
    .programming_voltage_input_ok(programming_voltage_input_s),
    .prog_data(shift_ff[OTP_W-1:0]),
    .fuse_q(fuse_q),
    .prog_done(prog_done),
    .prog_refused(prog_refused)
  );

  // Sticky events, set wins over write-one clear
  logic align_good_d_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      align_good_d_ff <= 1'b0;
    end else begin
      align_good_d_ff <= align_mode_ff && align_good;
    end
  end

  always_comb begin
    evt = '0;
    evt[EV_FRAME] = frame_done_ff;
    evt[EV_PROG_OK] = prog_done;
    evt[EV_PROG_REFUSED] = prog_refused;
    evt[EV_ALIGN_GOOD] = align_mode_ff && align_good && !align_good_d_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      status_ff <= '0;
      mask_ff <= '0;
    end else begin
      if (apb_wr && paddr == REG_STATUS) begin
        status_ff <= (status_ff & ~pwdata[EVT_W-1:0]) | evt;
      end else begin
        status_ff <= status_ff | evt;
      end
      if (apb_wr && paddr == REG_MASK) begin
        mask_ff <= pwdata[EVT_W-1:0];
      end
    end
  end

  assign irq = |(status_ff & mask_ff);

  // APB read path, data captured in setup phase
  logic [DATA_W-1:0] prdata_ff, rd_mux;
  logic err_ff, rd_hit;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr)
      REG_CTRL: begin
        rd_mux[CTRL_ALIGN] = align_mode_ff;
        rd_mux[CTRL_MAGCOMP] = magcomp_ff;
        rd_mux[CTRL_CCW] = ccw_ff;
        rd_mux[CTRL_PWMDIS] = pwmdis_ff;
      end
      REG_ZERO: rd_mux[ANG_W-1:0] = zero_ff;
      REG_STATUS: rd_mux[EVT_W-1:0] = status_ff;
      REG_MASK: rd_mux[EVT_W-1:0] = mask_ff;
      REG_OTP: rd_mux[OTP_W-1:0] = fuse_q;
      REG_POS: begin
        rd_mux[ANG_W-1:0] = pos_ff;
        rd_mux[POS_INC] = inc_flag_ff;
        rd_mux[POS_DEC] = dec_flag_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata_ff <= '0;
      err_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff <= pwrite ? '0 : rd_mux;
      err_ff <= !rd_hit;
    end
  end

  assign prdata = prdata_ff;
  assign pready = psel && penable;
  assign pslverr = psel && penable && err_ff;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence seq_power_up;
    !nrst ##1 nrst;
  endsequence

  sequence seq_send_start;
    (link_ff == EOC_LK_IDLE) && cs_fall && !prog_s;
  endsequence

  align_field_a: assert property (
    seq_send_start |=> shift_ff[FR_ANG_LSB +: ANG_W] ==
      ($past(align_mode_ff) ? $past(misalign_mag) : $past(pos_ff)))
    else $error("angle field not from selected source");

  align_flags_a: assert property (
    align_mode_ff && align_good && !wr_ctrl
      |=> !field_increase_flag_n && !field_decrease_flag_n)
    else $error("flag pins not low on good alignment");

  mode_back_a: assert property (
    wr_ctrl && !pwdata[CTRL_ALIGN] |=> !align_mode_ff ##1
      (!align_mode_ff || $past(wr_ctrl)))
    else $error("alignment mode not left");

  zero_write_a: assert property (
    wr_zero && !load_pend_ff && !reload_req
      |=> zero_ff == $past(pwdata[ANG_W-1:0]))
    else $error("zero offset write lost");

  power_load_a: assert property (
    disable iff (1'b0) seq_power_up |=> nrst -> (zero_ff ==
      $past(fuse_q[OTP_ZERO_LSB +: ANG_W]) && ccw_ff == $past(fuse_q[OTP_CCW])))
    else $error("fuse image not loaded after reset");

  fuse_hold_a: assert property (
    disable iff (!otp_blank_n || !nrst) ((~$past(fuse_q)) | fuse_q) == '1)
    else $error("programmed fuse returned to zero");

  no_voltage_a: assert property (
    disable iff (!otp_blank_n) prog_pulse_ff && !programming_voltage_input_s
      |=> fuse_q == $past(fuse_q) && prog_refused)
    else $error("fuses changed without programming voltage");

  ccw_invert_a: assert property (
    ccw_ff && !load_pend_ff |=> pos_ff ==
      wrap_sub('0, wrap_sub($past(raw_angle), $past(zero_ff))))
    else $error("reversed position wrong");

  otp_read_a: assert property (
    apb_setup && !pwrite && paddr == REG_OTP
      |=> prdata[OTP_W-1:0] == $past(fuse_q))
    else $error("fuse readback mismatch");

  irq_level_a: assert property (
    (evt & mask_ff) != '0 && !(apb_wr && paddr == REG_MASK) |=> irq)
    else $error("unmasked event raised no interrupt");
endmodule // eoc_encoder_cfg
`default_nettype wire

/* tb/eoc_ctl_model.sv */
// Serial controller model driving the encoder's sync serial pins.
// Assumes ref_clk at 40 MHz; one link clock period is 8 ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module eoc_ctl_model (
  input wire logic ref_clk,
  input wire logic serial_data_o,
  input wire logic serial_data_oe,
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_data_i,
  output logic prog_pin
);
  logic drv;
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b1;
    serial_data_i = 1'b0;
    prog_pin = 1'b0;
    drv = 1'b0;
  end
  // Released data line toggles, never a stale level
  always @(posedge ref_clk) if (!drv) serial_data_i <= ~serial_data_i;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One frame; rx gives a programming frame, pg the prog pin level
  task automatic xfer(input logic pg, input logic rx,
                      input logic [15:0] wd, input int nb,
                      output logic [15:0] rd);
    rd = '0;
    @(posedge ref_clk);
    prog_pin <= pg;
    serial_clk <= !rx;
    drv <= rx;
    tick(4);
    chip_select_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      tick(4);
      serial_clk <= 1'b0;
      if (rx) serial_data_i <= wd[nb-1-i];
      tick(4);
      // Released line reads low through its pull-down
      rd = {rd[14:0], serial_data_oe && serial_data_o};
      serial_clk <= 1'b1;
    end
    tick(4);
    chip_select_n <= 1'b1;
    drv <= 1'b0;
    tick(8);
    prog_pin <= 1'b0;
  endtask
endmodule // eoc_ctl_model
`default_nettype wire

/* tb/tb_top.sv */
// Top bench: APB master, sensor stimulus and serial controller model.
// Assumes eoc_pkg, the encoder block and the controller model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eoc_pkg::*;
  logic ref_clk, nrst, otp_blank_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rv;
  logic [ANG_W-1:0] raw_angle, misalign_mag, abs_position;
  logic chip_select_n, serial_clk, serial_data_i, serial_data_o, prog_pin;
  logic programming_voltage_input, field_increase_flag_n, se;
  logic field_decrease_flag_n, inc_dir, irq;
  logic serial_data_oe, inc_step, field_too_weak, field_too_strong;
  logic magnet_compensation_enable, pulse_width_output_disable;
  logic [15:0] fr;
  int errors = 0;
  int num_checks = 0;
  int n_steps = 0;
  eoc_encoder_cfg dut (
    .ref_clk, .nrst, .otp_blank_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .raw_angle, .misalign_mag,
    .field_too_weak, .field_too_strong, .chip_select_n,
    .serial_clk, .serial_data_i, .serial_data_o, .serial_data_oe,
    .prog_pin, .programming_voltage_input, .field_increase_flag_n,
    .field_decrease_flag_n, .abs_position, .inc_step, .inc_dir,
    .magnet_compensation_enable, .pulse_width_output_disable, .irq
  );
  eoc_ctl_model u_ctl (
    .ref_clk, .serial_data_o, .serial_data_oe, .chip_select_n, .serial_clk,
    .serial_data_i, .prog_pin
  );
  // Counts incremental step pulses
  always @(posedge ref_clk) if (inc_step === 1'b1) n_steps <= n_steps + 1;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      tally_and_finish();
    end
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rv, exp);
  endtask
  task automatic wait_pos(input logic [ANG_W-1:0] exp);
    int n;
    n = 0;
    while (abs_position !== exp && n < 32) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 32) begin
      errors++;
      tally_and_finish();
    end
    @(posedge ref_clk);
    chk({22'h0, abs_position}, {22'h0, exp});
  endtask
  task automatic t_regs();
    rdc(REG_CTRL, 32'h0);
    rdc(REG_ZERO, 32'h0);
    rdc(REG_OTP, 32'h0);
    rdc(8'h18, 32'h0);
    chk({31'h0, se}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_align();
    misalign_mag <= 10'h01f;
    raw_angle <= 10'h155;
    apb(1'b1, REG_CTRL, 32'h1);
    rdc(REG_STATUS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_MASK, 32'h8);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, REG_STATUS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    chk({30'h0, field_increase_flag_n, field_decrease_flag_n}, 32'h0);
    u_ctl.xfer(1'b0, 1'b0, 16'h0, 16, fr);
    chk({16'h0, fr}, {16'h0, 10'h01f, 6'b111000});
    misalign_mag <= 10'h020;
    u_ctl.xfer(1'b0, 1'b0, 16'h0, 16, fr);
    chk({22'h0, fr[15:6]}, 32'h20);
    apb(1'b1, REG_CTRL, 32'h0);
    u_ctl.xfer(1'b0, 1'b0, 16'h0, 16, fr);
    chk({16'h0, fr}, {16'h0, 10'h155, 6'h0});
    chk({30'h0, field_increase_flag_n, field_decrease_flag_n}, 32'h3);
    field_too_weak <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({30'h0, field_increase_flag_n, field_decrease_flag_n}, 32'h1);
    field_too_weak <= 1'b0;
    field_too_strong <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({30'h0, field_increase_flag_n, field_decrease_flag_n}, 32'h2);
    field_too_strong <= 1'b0;
    apb(1'b1, REG_STATUS, 32'hf);
    $display("test align done");
  endtask
  task automatic t_runtime();
    int s0;
    s0 = n_steps;
    apb(1'b1, REG_ZERO, 32'h100);
    wait_pos(10'h055);
    raw_angle <= 10'h156;
    wait_pos(10'h056);
    chk({31'h0, inc_dir}, 32'h1);
    apb(1'b1, REG_CTRL, 32'he);
    wait_pos(10'h3aa);
    chk({30'h0, magnet_compensation_enable,
         pulse_width_output_disable}, 32'h3);
    raw_angle <= 10'h157;
    wait_pos(10'h3a9);
    chk({31'h0, inc_dir}, 32'h0);
    rdc(REG_POS, 32'h3a9);
    chk(n_steps - s0, 32'h4);
    $display("test runtime done");
  endtask
  task automatic t_otp();
    programming_voltage_input <= 1'b0;
    apb(1'b1, REG_MASK, 32'h6);
    u_ctl.xfer(1'b1, 1'b1, 16'h0155, 13, fr);
    apb(1'b0, REG_STATUS, '0);
    chk(rv & 32'h6, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rdc(REG_OTP, 32'h0);
    programming_voltage_input <= 1'b1;
    apb(1'b1, REG_STATUS, 32'hf);
    u_ctl.xfer(1'b1, 1'b1, 16'h1003, 13, fr);
    apb(1'b0, REG_STATUS, '0);
    chk(rv & 32'h6, 32'h2);
    rdc(REG_OTP, 32'h1003);
    u_ctl.xfer(1'b1, 1'b1, 16'h0800, 13, fr);
    rdc(REG_OTP, 32'h1803);
    u_ctl.xfer(1'b1, 1'b0, 16'h0, 13, fr);
    chk({19'h0, fr[12:0]}, 32'h1803);
    programming_voltage_input <= 1'b0;
    apb(1'b1, REG_ZERO, 32'h2aa);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdc(REG_CTRL, 32'ha);
    rdc(REG_ZERO, 32'h3);
    chk({30'h0, magnet_compensation_enable,
         pulse_width_output_disable}, 32'h3);
    apb(1'b1, REG_ZERO, 32'h2aa);
    apb(1'b1, REG_CTRL, 32'h10);
    rdc(REG_ZERO, 32'h3);
    rdc(REG_CTRL, 32'ha);
    $display("test otp done");
  endtask
  initial begin
    nrst = 1'b0;
    otp_blank_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    raw_angle = '0;
    misalign_mag = 10'h3ff;
    programming_voltage_input = 1'b0;
    field_too_weak = 1'b0;
    field_too_strong = 1'b0;
    @(posedge ref_clk);
    otp_blank_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_regs();
    t_align();
    t_runtime();
    t_otp();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
